// File: verilog/swcr_timer_unit.v
// Purpose: one timer able to run as a 16-bit counter or as two 8-bit halves
// Assumes: ticks and capture events are single-cycle pulses on the core clock
// Notes:   software writes land in the same cycle they are presented
`timescale 1ns/1ns
`include "swcr_consts.vh"

module swcr_timer_unit (
    input  wire       clk,
    input  wire       srst,
    input  wire [7:0] wdata,
    input  wire       wr_ctrl,
    input  wire       wr_rl,
    input  wire       wr_rh,
    input  wire       wr_cl,
    input  wire       wr_ch,
    input  wire       tick_lo,
    input  wire       tick_hi,
    input  wire       cap_lo,
    input  wire       cap_hi,
    output reg  [7:0] ctrl_r,
    output reg  [7:0] rl_r,
    output reg  [7:0] rh_r,
    output reg  [7:0] cl_r,
    output reg  [7:0] ch_r,
    output wire       irq
);
    reg  [7:0] ctrl_nxt;
    reg  [7:0] rl_nxt;
    reg  [7:0] rh_nxt;
    reg  [7:0] cl_nxt;
    reg  [7:0] ch_nxt;
    reg        set_inth;
    reg        set_intl;
    wire       split;
    wire       lo_run;
    wire       hi_run;
    wire       lo_cap;
    wire       hi_cap;
    wire       wide_step;
    wire       lo_step;
    wire       hi_step;
    wire       lo_ovf;
    wire       hi_ovf;
    wire       wide_ovf;
    wire       lo_capt;
    wire       hi_capt;
    wire [15:0] wide_inc;

    assign split     = ctrl_r[`SWCR_SPLIT_SELECT];                        // RL14
    assign lo_run    = ctrl_r[`SWCR_LOW_RUN];                             // RL17
    assign hi_run    = split & ctrl_r[`SWCR_HIGH_RUN];
    assign lo_cap    = ctrl_r[`SWCR_LOW_CAP_ENABLE];                      // RL16
    assign hi_cap    = split & ctrl_r[`SWCR_HIGH_CAP_ENABLE];             // RL16
    assign wide_step = ~split & lo_run & tick_lo;                         // RL17
    assign lo_step   = split & lo_run & tick_lo;
    assign hi_step   = hi_run & tick_hi;
    assign lo_ovf    = (wide_step | lo_step) & (cl_r == `SWCR_BYTE_MAX);
    assign hi_ovf    = hi_step & (ch_r == `SWCR_BYTE_MAX);
    assign wide_ovf  = wide_step & ({ch_r, cl_r} == `SWCR_WIDE_MAX);
    assign lo_capt   = lo_cap & cap_lo;
    assign hi_capt   = hi_cap & cap_hi;
    assign wide_inc  = {ch_r, cl_r} + 16'h0001;

    // high flag alone, or low flag gated by its enable
    assign irq = ctrl_r[`SWCR_HIGH_HALF_FLAG] |
                 (ctrl_r[`SWCR_LOW_HALF_FLAG] & ctrl_r[`SWCR_LOW_IRQ_ENABLE]);   // RL15

    always @* begin
        if (split) begin
            set_inth = hi_cap ? hi_capt : hi_ovf;                         // RL7
            set_intl = lo_cap ? lo_capt : lo_ovf;                         // RL9
        end else begin
            set_inth = lo_cap ? lo_capt : wide_ovf;                       // RL13
            // in wide capture the flag becomes a 17th count bit
            set_intl = lo_cap ? wide_ovf : lo_ovf;                        // RL11 RL12
        end
    end

    always @* begin
        ctrl_nxt = wr_ctrl ? wdata : ctrl_r;
        // set wins over a software clear in the same cycle
        ctrl_nxt[`SWCR_HIGH_HALF_FLAG] = ctrl_nxt[`SWCR_HIGH_HALF_FLAG] | set_inth;  // RL8
        ctrl_nxt[`SWCR_LOW_HALF_FLAG]  = ctrl_nxt[`SWCR_LOW_HALF_FLAG] | set_intl;   // RL10

        rl_nxt = wr_rl ? wdata : rl_r;                                    // RL3
        rh_nxt = wr_rh ? wdata : rh_r;                                    // RL3 RL4
        // a capture beats a software write of the same byte
        if (lo_capt) begin
            rl_nxt = cl_r;                                                // RL1
            if (!split) begin
                rh_nxt = ch_r;
            end
        end
        if (hi_capt) begin
            rh_nxt = ch_r;
        end

        cl_nxt = cl_r;
        ch_nxt = ch_r;
        if (wide_step) begin
            if (wide_ovf && !lo_cap) begin
                cl_nxt = rl_r;                                            // RL2 RL18
                ch_nxt = rh_r;
            end else begin
                cl_nxt = wide_inc[7:0];                                   // RL5
                ch_nxt = wide_inc[15:8];                                  // RL6
            end
        end
        if (lo_step) begin
            cl_nxt = (lo_ovf && !lo_cap) ? rl_r : cl_r + 8'h01;           // RL2 RL18
        end
        if (hi_step) begin
            ch_nxt = (hi_ovf && !hi_cap) ? rh_r : ch_r + 8'h01;           // RL18
        end
        // software writes to the live count win over counting
        if (wr_cl) begin
            cl_nxt = wdata;
        end
        if (wr_ch) begin
            ch_nxt = wdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ctrl_r <= `SWCR_REG_RESET;
            rl_r   <= `SWCR_REG_RESET;
            rh_r   <= `SWCR_REG_RESET;
            cl_r   <= `SWCR_REG_RESET;
            ch_r   <= `SWCR_REG_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            rl_r   <= rl_nxt;
            rh_r   <= rh_nxt;
            cl_r   <= cl_nxt;
            ch_r   <= ch_nxt;
        end
    end
endmodule // swcr_timer_unit

// File: shared/swcr_consts.vh
// Purpose: offsets, bit positions and reset values of the split/wide timer pair
// Assumes: 8-bit special-function register space, byte-wide registers
// Notes:   timer a and timer b share one bit layout for their control registers
`ifndef SWCR_CONSTS_VH
`define SWCR_CONSTS_VH

// timer a register offsets
`define SWCR_A_CTRL_ADDR      8'hC8
`define SWCR_A_RL_ADDR        8'hCA
`define SWCR_A_RH_ADDR        8'hCB
`define SWCR_A_CL_ADDR        8'hCC
`define SWCR_A_CH_ADDR        8'hCD

// timer b register offsets
`define SWCR_B_CTRL_ADDR      8'hB9
`define SWCR_B_RL_ADDR        8'hBA
`define SWCR_B_RH_ADDR        8'hBB
`define SWCR_B_CL_ADDR        8'hBC
`define SWCR_B_CH_ADDR        8'hBD

// control register fields
`define SWCR_HIGH_HALF_FLAG   7
`define SWCR_LOW_HALF_FLAG    6
`define SWCR_LOW_IRQ_ENABLE   5
`define SWCR_SPLIT_SELECT     4
`define SWCR_HIGH_CAP_ENABLE  3
`define SWCR_LOW_CAP_ENABLE   2
`define SWCR_HIGH_RUN         1
`define SWCR_LOW_RUN          0

// reset values and count limits
`define SWCR_REG_RESET        8'h00
`define SWCR_BYTE_MAX         8'hFF
`define SWCR_WIDE_MAX         16'hFFFF
`define SWCR_RDATA_UNMAPPED   8'h00

`endif

// File: verilog/swcr_timer_pair.v
// Purpose: two split/wide capture-reload timers behind the special-function register port
// Assumes: tick and capture inputs come from logic on CORE_CLK (50 MHz)
// Notes:   read data are registered, one cycle after the read strobe
//
// Notes on behaviour
// [RL1] capture mode stores the captured count in the low reload/capture byte
// [RL2] timer mode reloads the counter from the low reload/capture byte
// [RL3] reload bytes are single-buffered; writes take effect immediately
// [RL4] high reload/capture byte holds upper reload bits, readable and writable
// [RL5] low count register: low byte of wide count, or whole low half
// [RL6] high count register: high byte of wide count, or whole high half
// [RL7] high flag sets on high-half or wide overflow in timer mode, or on capture in capture mode
// [RL8] hardware never clears the high flag; software writes it to zero
// [RL9] low flag sets on low-half overflow in timer mode or capture
// [RL10] low flag cleared only by software
// [RL11] low-byte overflow sets low flag even in wide timer configuration
// [RL12] wide capture mode: high-byte overflow sets low flag, a 17th bit
// [RL13] wide capture mode: capture event sets only the high flag
// [RL14] split select: zero wide 16-bit under low controls, one independent halves
// [RL15] interrupt request is high flag or low flag with its enable
// [RL16] low capture enable selects capture; high one ignored in wide mode
// [RL17] low run enables low half, or the whole timer when wide
// [RL18] each tick increments; in timer mode overflow reloads and raises the matching flag
`timescale 1ns/1ns
`include "swcr_consts.vh"

module swcr_timer_pair (
    input  wire       CORE_CLK,
    input  wire       SRST,
    input  wire [7:0] SFR_ADDR,
    input  wire [7:0] SFR_WDATA,
    input  wire       SFR_WR,
    input  wire       SFR_RD,
    output reg  [7:0] SFR_RDATA,
    input  wire       TICK_A_LO,
    input  wire       TICK_A_HI,
    input  wire       TICK_B_LO,
    input  wire       TICK_B_HI,
    input  wire       CAPTURE_A_LO,
    input  wire       CAPTURE_A_HI,
    input  wire       CAPTURE_B_LO,
    input  wire       CAPTURE_B_HI,
    output wire       IRQ_A,
    output wire       IRQ_B
);
    wire [7:0] a_ctrl;
    wire [7:0] a_rl;
    wire [7:0] a_rh;
    wire [7:0] a_cl;
    wire [7:0] a_ch;
    wire [7:0] b_ctrl;
    wire [7:0] b_rl;
    wire [7:0] b_rh;
    wire [7:0] b_cl;
    wire [7:0] b_ch;
    reg  [7:0] rd_mux;

    swcr_timer_unit u_timer_a (
        .clk     (CORE_CLK),
        .srst    (SRST),
        .wdata   (SFR_WDATA),
        .wr_ctrl (SFR_WR && SFR_ADDR == `SWCR_A_CTRL_ADDR),
        .wr_rl   (SFR_WR && SFR_ADDR == `SWCR_A_RL_ADDR),               // RL3
        .wr_rh   (SFR_WR && SFR_ADDR == `SWCR_A_RH_ADDR),               // RL4
        .wr_cl   (SFR_WR && SFR_ADDR == `SWCR_A_CL_ADDR),
        .wr_ch   (SFR_WR && SFR_ADDR == `SWCR_A_CH_ADDR),
        .tick_lo (TICK_A_LO),
        .tick_hi (TICK_A_HI),
        .cap_lo  (CAPTURE_A_LO),
        .cap_hi  (CAPTURE_A_HI),
        .ctrl_r  (a_ctrl),
        .rl_r    (a_rl),
        .rh_r    (a_rh),
        .cl_r    (a_cl),
        .ch_r    (a_ch),
        .irq     (IRQ_A)
    );

    swcr_timer_unit u_timer_b (
        .clk     (CORE_CLK),
        .srst    (SRST),
        .wdata   (SFR_WDATA),
        .wr_ctrl (SFR_WR && SFR_ADDR == `SWCR_B_CTRL_ADDR),
        .wr_rl   (SFR_WR && SFR_ADDR == `SWCR_B_RL_ADDR),
        .wr_rh   (SFR_WR && SFR_ADDR == `SWCR_B_RH_ADDR),
        .wr_cl   (SFR_WR && SFR_ADDR == `SWCR_B_CL_ADDR),
        .wr_ch   (SFR_WR && SFR_ADDR == `SWCR_B_CH_ADDR),
        .tick_lo (TICK_B_LO),
        .tick_hi (TICK_B_HI),
        .cap_lo  (CAPTURE_B_LO),
        .cap_hi  (CAPTURE_B_HI),
        .ctrl_r  (b_ctrl),
        .rl_r    (b_rl),
        .rh_r    (b_rh),
        .cl_r    (b_cl),
        .ch_r    (b_ch),
        .irq     (IRQ_B)
    );

    // reads have no side effect; flags clear only by explicit write
    always @* begin
        case (SFR_ADDR)
            `SWCR_A_CTRL_ADDR: rd_mux = a_ctrl;
            `SWCR_A_RL_ADDR:   rd_mux = a_rl;                           // RL1
            `SWCR_A_RH_ADDR:   rd_mux = a_rh;                           // RL4
            `SWCR_A_CL_ADDR:   rd_mux = a_cl;                           // RL5
            `SWCR_A_CH_ADDR:   rd_mux = a_ch;                           // RL6
            `SWCR_B_CTRL_ADDR: rd_mux = b_ctrl;
            `SWCR_B_RL_ADDR:   rd_mux = b_rl;
            `SWCR_B_RH_ADDR:   rd_mux = b_rh;
            `SWCR_B_CL_ADDR:   rd_mux = b_cl;
            `SWCR_B_CH_ADDR:   rd_mux = b_ch;
            default:           rd_mux = `SWCR_RDATA_UNMAPPED;
        endcase
    end

    // registered read keeps the output glitch-free at the cost of one cycle
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            SFR_RDATA <= `SWCR_REG_RESET;
        end else if (SFR_RD) begin
            SFR_RDATA <= rd_mux;
        end
    end
endmodule // swcr_timer_pair

// File: dv/swcr_timer_pair_sva.sv
// Purpose: port-level checker for the split/wide timer pair
// Assumes: one clock domain, synchronous active-high reset
// Notes:   counts are internal, so the bench reads them back
`timescale 1ns/1ns
module swcr_timer_pair_sva (
    input wire       CORE_CLK,
    input wire       SRST,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire       SFR_WR,
    input wire       SFR_RD,
    input wire [7:0] SFR_RDATA,
    input wire       TICK_A_LO,
    input wire       TICK_A_HI,
    input wire       TICK_B_LO,
    input wire       TICK_B_HI,
    input wire       CAPTURE_A_LO,
    input wire       CAPTURE_A_HI,
    input wire       CAPTURE_B_LO,
    input wire       CAPTURE_B_HI,
    input wire       IRQ_A,
    input wire       IRQ_B
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // capture may overwrite the reload bytes, so it is excluded
    wire cap_a = CAPTURE_A_LO | CAPTURE_A_HI;
    wire wr_a  = SFR_WR && SFR_ADDR == 8'hC8;
    wire wr_b  = SFR_WR && SFR_ADDR == 8'hB9;

    // write, one idle edge, then a read of the same byte
    a_rl_readback: assert property (
        SFR_WR && SFR_ADDR == 8'hCA && !cap_a ##1 !SFR_WR && !cap_a
        ##1 SFR_RD && !SFR_WR && SFR_ADDR == 8'hCA && !cap_a
        |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("reload low readback");
    a_rh_readback: assert property (
        SFR_WR && SFR_ADDR == 8'hCB && !cap_a ##1 !SFR_WR && !cap_a
        ##1 SFR_RD && !SFR_WR && SFR_ADDR == 8'hCB && !cap_a
        |=> SFR_RDATA == $past(SFR_WDATA, 3)) else $error("reload high readback");
    a_irqa_formula: assert property (SFR_RD && SFR_ADDR == 8'hC8 |=>
        $past(IRQ_A) == (SFR_RDATA[7] | (SFR_RDATA[6] & SFR_RDATA[5]))) else $error("irq a");
    a_irqb_formula: assert property (SFR_RD && SFR_ADDR == 8'hB9 |=>
        $past(IRQ_B) == (SFR_RDATA[7] | (SFR_RDATA[6] & SFR_RDATA[5]))) else $error("irq b");
    a_irqa_hold: assert property ($fell(IRQ_A) |-> $past(wr_a)) else $error("irq a dropped");
    a_irqb_hold: assert property ($fell(IRQ_B) |-> $past(wr_b)) else $error("irq b dropped");
    a_irqa_cause: assert property ($rose(IRQ_A) |->
        $past(TICK_A_LO | TICK_A_HI | cap_a | wr_a)) else $error("irq a without cause");
    a_irqb_cause: assert property ($rose(IRQ_B) |->
        $past(TICK_B_LO | TICK_B_HI | CAPTURE_B_LO | CAPTURE_B_HI | wr_b))
        else $error("irq b without cause");

    cover property (TICK_A_LO ##1 IRQ_A);
    cover property (CAPTURE_A_LO ##1 SFR_RD);
    cover property ($fell(IRQ_B));
endmodule // swcr_timer_pair_sva

bind swcr_timer_pair swcr_timer_pair_sva u_swcr_timer_pair_sva (.CORE_CLK, .SRST, .SFR_ADDR,
    .SFR_WDATA, .SFR_WR, .SFR_RD, .SFR_RDATA, .TICK_A_LO, .TICK_A_HI, .TICK_B_LO, .TICK_B_HI,
    .CAPTURE_A_LO, .CAPTURE_A_HI, .CAPTURE_B_LO, .CAPTURE_B_HI, .IRQ_A, .IRQ_B);

// File: dv/testbench.sv
// Purpose: register-level tests of the split/wide timer pair
// Assumes: inputs change on the falling edge of the core clock
// Notes:   expectations come from the register rules, never from outputs
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    logic       clk   = 1'b0;
    logic       srst  = 1'b1;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] ev    = 8'h00;
    wire  [7:0] rdata;
    wire        irq_a;
    wire        irq_b;
    int         errors = 0;
    int         checks = 0;
    logic [7:0] regs [10] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
                              8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD};
    always #10 clk = ~clk;
    swcr_timer_pair u_swcr_timer_pair (.CORE_CLK(clk), .SRST(srst), .SFR_ADDR(addr),
        .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata),
        .TICK_A_LO(ev[0]), .TICK_A_HI(ev[1]), .TICK_B_LO(ev[2]), .TICK_B_HI(ev[3]),
        .CAPTURE_A_LO(ev[4]), .CAPTURE_A_HI(ev[5]), .CAPTURE_B_LO(ev[6]),
        .CAPTURE_B_HI(ev[7]), .IRQ_A(irq_a), .IRQ_B(irq_b));
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        // idle edge so back-to-back calls never toggle a strobe twice at once
        @(negedge clk);
    endtask
    // read data is registered, so it is sampled one edge after the strobe
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        `CHK($sformatf("reg_%h", a), e, rdata)
        @(negedge clk);
    endtask
    task automatic p(input logic [7:0] m);
        ev = m;
        @(negedge clk);
        ev = 8'h00;
        @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        errors++;
        $display("MISMATCH watchdog exp done got timeout");
        wrap_up;
    end
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 10; i++) r(regs[i], 8'h00);
        w(8'h00, 8'hFF);
        r(8'h00, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) begin
            w(regs[i], 8'(8'h30 + i));
            r(regs[i], 8'(8'h30 + i));
        end
        $display("test readback done");
        w(8'hCA, 8'h34); w(8'hCB, 8'h12); w(8'hCC, 8'hFF); w(8'hCD, 8'hFF); w(8'hC8, 8'h01);
        p(8'h01);
        `CHK("irq_a", 1'b1, irq_a)
        r(8'hCC, 8'h34);
        r(8'hCD, 8'h12);
        r(8'hC8, 8'hC1);
        p(8'h02);
        p(8'h01);
        r(8'hCD, 8'h12);
        r(8'hCC, 8'h35);
        w(8'hCC, 8'hFF);
        w(8'hC8, 8'h01);
        p(8'h01);
        r(8'hCC, 8'h00);
        r(8'hCD, 8'h13);
        r(8'hC8, 8'h41);
        `CHK("irq_a", 1'b0, irq_a)
        $display("test wide_reload done");
        w(8'hC8, 8'h41);
        `CHK("irq_a", 1'b0, irq_a)
        w(8'hC8, 8'h61);
        `CHK("irq_a", 1'b1, irq_a)
        w(8'hC8, 8'h01);
        repeat (3) @(negedge clk);
        r(8'hC8, 8'h01);
        $display("test flag_clear done");
        w(8'hBA, 8'hF0); w(8'hBB, 8'h80); w(8'hBC, 8'hFF); w(8'hBD, 8'hFE); w(8'hB9, 8'h13);
        p(8'h08);
        r(8'hBD, 8'hFF);
        r(8'hB9, 8'h13);
        p(8'h08);
        r(8'hBD, 8'h80);
        r(8'hB9, 8'h93);
        p(8'h04);
        r(8'hBC, 8'hF0);
        r(8'hB9, 8'hD3);
        `CHK("irq_b", 1'b1, irq_b)
        $display("test split_timer done");
        w(8'hB9, 8'h1C); w(8'hBC, 8'h3C); w(8'hBD, 8'h4D);
        p(8'h40);
        r(8'hBA, 8'h3C);
        r(8'hB9, 8'h5C);
        p(8'h80);
        r(8'hB9, 8'hDC);
        r(8'hBB, 8'h4D);
        $display("test split_capture done");
        w(8'hC8, 8'h04); w(8'hCC, 8'h78); w(8'hCD, 8'h56);
        p(8'h10);
        r(8'hCA, 8'h78);
        r(8'hC8, 8'h84);
        w(8'hC8, 8'h05); w(8'hCC, 8'hFF); w(8'hCD, 8'hFF);
        p(8'h01);
        r(8'hCC, 8'h00);
        r(8'hC8, 8'h45);
        $display("test wide_capture done");
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        `CHK("irq_b", 1'b0, irq_b)
        r(8'hCB, 8'h00);
        r(8'hB9, 8'h00);
        $display("test mid_reset done");
        wrap_up;
    end
endmodule // testbench
